//--- common/gpt_pkg.sv
// Constants, modes and carriers of the general purpose timer unit
package gpt_pkg;
   localparam int TMR_W   = 16;
   localparam int NUM_TMR = 5;
   localparam int NUM_A   = 3;
   localparam int PS_W    = 10;
   localparam int AW      = 8;
   // Timer index map
   localparam int T_ACORE = 0;
   localparam int T_ALOW  = 1;
   localparam int T_AHIGH = 2;
   localparam int T_BAUX  = 3;
   localparam int T_BCORE = 4;
   // Prescaler shift: module A divides 8..1024, module B 4..512
   localparam logic [3:0] PS_SHIFT_A = 4'h3;
   localparam logic [3:0] PS_SHIFT_B = 4'h2;
   // Register map, one aligned word each
   localparam logic [7:0] OFF_CTRL0  = 8'h00;
   localparam logic [7:0] OFF_VAL0   = 8'h14;
   localparam logic [7:0] OFF_CAPTURE_RELOAD_REG = 8'h28;
   localparam logic [7:0] REG_STRIDE = 8'h04;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] VAL_RST   = 16'h0000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Capture trigger sources
   localparam logic [1:0] CAP_PIN      = 2'h0;
   localparam logic [1:0] CAP_CORE_IN  = 2'h1;
   localparam logic [1:0] CAP_CORE_DIR = 2'h2;

   typedef enum logic [2:0] {
      MODE_TIMER   = 3'h0,
      MODE_COUNT   = 3'h1,
      MODE_GATEHI  = 3'h2,
      MODE_GATELO  = 3'h3,
      MODE_RELOAD  = 3'h4,
      MODE_CAPTURE = 3'h5,
      MODE_INCR    = 3'h6,
      MODE_CHAIN   = 3'h7
   } gpt_mode_t;

   // Control word, bit 15 reads zero
   typedef struct packed {
      logic [1:0] capSrc;
      logic       clrCap;
      logic       relEn;
      logic [1:0] edgeSel;
      logic       extDir;
      logic       down;
      logic       run;
      gpt_mode_t  mode;
      logic [2:0] inSel;
   } gpt_ctrl_t;

   typedef struct packed {
      logic       cap;
      logic [1:0] bDir;
      logic [1:0] bIn;
      logic [2:0] aDir;
      logic [2:0] aIn;
   } gpt_pins_t;
endpackage

//--- verilog/gpt_timer16.sv
// One up/down timer cell with load and wrap detection
`timescale 1ns/10ps
module gpt_timer16 import gpt_pkg::*; #(
   parameter int TW = TMR_W
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          reset_n,
   input  wire logic          ce,
   // Control
   input  wire logic          cntEn,
   input  wire logic          down,
   input  wire logic          load,
   input  wire logic [TW-1:0] loadVal,
   // State
   output logic      [TW-1:0] value,
   output logic               wrap
);
   logic [TW-1:0] next_value;

   // Wrap is modulo 2^TW, also when a load hides it
   assign wrap = cntEn & (down ? (value == '0) : (&value));

   always_comb begin
      next_value = value;
      if (load) begin
         next_value = loadVal;
      end else if (cntEn) begin
         next_value = down ? value - 1'b1 : value + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         value <= TW'(VAL_RST);
      end else if (ce) begin
         value <= next_value;
      end
   end
endmodule // gpt_timer16

//--- verilog/gpt_top.sv
// Summary of operation
// - Five 16-bit timers, three in module A, two in module B.
// - Each module A timer picks timer, gated, counter or quadrature mode.
// - Module A timer mode divides clock by 8 up to 1024.
// - Module B timers divide clock by 4 up to 512.
// - Counter mode advances on selected edges of the timer input pin.
// - Gated mode counts prescaled ticks only while the gate level allows.
// - Quadrature mode derives count and direction from input and dir pins.
// - Module A core timer toggles its latch on every wrap.
// - Module A aux timers may count on core toggle latch changes.
// - Module A aux timers may act as reload or capture for core.
// - Module B: aux, core, capture/reload; prescaled or external clock.
// - Module B direction set by software, optionally flipped by dir pin.
// - Module B core toggles its latch on wrap; latch may clock aux.
// - Module B core wrap clocks capcom timers and reloads from capture reg.
// - Capture pin edge latches aux value, optionally clearing aux.
// - Capture may trigger from module A core input or direction pin.
// - Module B raises separate aux, core and capture requests.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module gpt_top import gpt_pkg::*; (
   // Clock, reset, enable
   input  wire logic          clk_sys,
   input  wire logic          reset_n,
   input  wire logic          ce,
   // AXI4-Lite slave
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // External pins
   input  wire gpt_pins_t     pinIn,
   // Toggle latch pins and events
   output logic               aToggleOut,
   output logic               bToggleOut,
   output logic               capcomTick,
   output logic               irqBAux,
   output logic               irqBCore,
   output logic               irqCap
);
   gpt_pins_t           pinMeta;
   gpt_pins_t           pinSync;
   gpt_pins_t           pinPrev;
   gpt_ctrl_t           ctrl [NUM_TMR];
   logic [TMR_W-1:0]    tVal [NUM_TMR];
   logic [TMR_W-1:0]    loadVal [NUM_TMR];
   logic [NUM_TMR-1:0]  loadEn;
   logic [NUM_TMR-1:0]  swLoad;
   logic [NUM_TMR-1:0]  swCtrl;
   logic [NUM_TMR-1:0]  cntEn;
   logic [NUM_TMR-1:0]  dn;
   logic [NUM_TMR-1:0]  wrap;
   logic [NUM_TMR-1:0]  inLvl;
   logic [NUM_TMR-1:0]  inRise;
   logic [NUM_TMR-1:0]  inFall;
   logic [NUM_TMR-1:0]  dirLvl;
   logic [NUM_TMR-1:0]  dirChg;
   logic [NUM_A-1:0]    inPrvA;
   logic [PS_W-1:0]     preCnt;
   logic [TMR_W-1:0]    capture_reload_reg;
   logic                aLatch;
   logic                capEv;
   logic                capRise;
   logic                capFall;
   logic [AW-1:0]       awAddr;
   logic [31:0]         wData;
   logic [3:0]          wStrb;
   logic                doWrite;
   logic                wrMap;
   logic                swCap;
   logic [31:0]         rdData;
   logic                rdHit;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   function automatic logic divTick(logic [PS_W-1:0] c, logic [3:0] n);
      logic [PS_W-1:0] m;
      m = ~({PS_W{1'b1}} << n);
      return (c & m) == m;
   endfunction

   function automatic logic edgeHit(logic [1:0] s, logic r, logic f);
      return (s[0] & r) | (s[1] & f);
   endfunction

   function automatic logic [15:0] applyStrb(logic [15:0] o,
                                             logic [31:0] d,
                                             logic [3:0] s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   function automatic logic [7:0] regAddr(logic [7:0] base, int i);
      return base + 8'(i) * REG_STRIDE;
   endfunction

   // Pin synchroniser, then one stage for edge detection
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta <= '0;
         pinSync <= '0;
         pinPrev <= '0;
      end else if (ce) begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   assign inLvl   = {pinSync.bIn, pinSync.aIn};
   assign inRise  = inLvl & ~{pinPrev.bIn, pinPrev.aIn};
   assign inFall  = ~inLvl & {pinPrev.bIn, pinPrev.aIn};
   assign dirLvl  = {pinSync.bDir, pinSync.aDir};
   assign dirChg  = dirLvl ^ {pinPrev.bDir, pinPrev.aDir};
   assign inPrvA  = pinPrev.aIn;
   assign capRise = pinSync.cap & ~pinPrev.cap;
   assign capFall = ~pinSync.cap & pinPrev.cap;

   // Free running prescaler shared by all timers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         preCnt <= '0;
      end else if (ce) begin
         preCnt <= preCnt + 1'b1;
      end
   end

   // Count enable and direction per timer
   always_comb begin
      logic pt;
      pt = 1'b0;
      cntEn = '0;
      dn = '0;
      for (int i = 0; i < NUM_TMR; i++) begin
         if (i < NUM_A) begin
            pt = divTick(preCnt, 4'(ctrl[i].inSel) + PS_SHIFT_A);
         end else begin
            pt = divTick(preCnt, 4'(ctrl[i].inSel) + PS_SHIFT_B);
         end
         dn[i] = ctrl[i].down ^ (ctrl[i].extDir & dirLvl[i]);
         case (ctrl[i].mode)
            MODE_TIMER: begin
               cntEn[i] = pt;
            end
            MODE_COUNT: begin
               cntEn[i] = edgeHit(ctrl[i].edgeSel, inRise[i], inFall[i]);
            end
            MODE_GATEHI: begin
               cntEn[i] = pt & inLvl[i];
            end
            MODE_GATELO: begin
               cntEn[i] = pt & ~inLvl[i];
            end
            MODE_INCR: begin
               // Four counts per sensor cycle; B leading A counts down
               if (i < NUM_A) begin
                  cntEn[i] = inRise[i] | inFall[i] | dirChg[i];
                  dn[i] = inPrvA[i] ^ dirLvl[i];
               end
            end
            MODE_CHAIN: begin
               if (i == T_ALOW || i == T_AHIGH) begin
                  cntEn[i] = edgeHit(ctrl[i].edgeSel, wrap[T_ACORE] & ~aLatch,
                                     wrap[T_ACORE] & aLatch);
               end else if (i == T_BAUX) begin
                  cntEn[i] = edgeHit(ctrl[i].edgeSel,
                                     wrap[T_BCORE] & ~bToggleOut,
                                     wrap[T_BCORE] & bToggleOut);
               end
            end
            default: begin
               // Reload and capture modes hold the value as a register
               cntEn[i] = 1'b0;
            end
         endcase
         cntEn[i] = cntEn[i] & ctrl[i].run;
      end
   end

   // Capture trigger of module B
   always_comb begin
      case (ctrl[T_BAUX].capSrc)
         CAP_PIN: begin
            capEv = edgeHit(ctrl[T_BAUX].edgeSel, capRise, capFall);
         end
         CAP_CORE_IN: begin
            capEv = inRise[T_ACORE] | inFall[T_ACORE];
         end
         CAP_CORE_DIR: begin
            capEv = dirChg[T_ACORE];
         end
         default: begin
            capEv = inRise[T_ACORE] | inFall[T_ACORE] | dirChg[T_ACORE];
         end
      endcase
      capEv = capEv & ctrl[T_BAUX].relEn;
   end

   // Register write decode
   assign doWrite = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign swCap = doWrite && (awAddr == OFF_CAPTURE_RELOAD_REG);
   always_comb begin
      swLoad = '0;
      swCtrl = '0;
      for (int i = 0; i < NUM_TMR; i++) begin
         swCtrl[i] = doWrite && (awAddr == regAddr(OFF_CTRL0, i));
         swLoad[i] = doWrite && (awAddr == regAddr(OFF_VAL0, i));
      end
      wrMap = (|swCtrl) | (|swLoad) | swCap;
   end

   // Timer loads; software write takes precedence over hardware
   always_comb begin
      for (int i = 0; i < NUM_TMR; i++) begin
         loadEn[i] = 1'b0;
         loadVal[i] = '0;
      end
      if (wrap[T_ACORE] && (ctrl[T_ALOW].mode == MODE_RELOAD ||
                            ctrl[T_AHIGH].mode == MODE_RELOAD)) begin
         loadEn[T_ACORE] = 1'b1;
         loadVal[T_ACORE] = (ctrl[T_ALOW].mode == MODE_RELOAD) ?
                            tVal[T_ALOW] : tVal[T_AHIGH];
      end
      for (int i = T_ALOW; i <= T_AHIGH; i++) begin
         if (ctrl[i].mode == MODE_CAPTURE &&
             edgeHit(ctrl[i].edgeSel, inRise[i], inFall[i])) begin
            loadEn[i] = 1'b1;
            loadVal[i] = tVal[T_ACORE];
         end
      end
      if (capEv && ctrl[T_BAUX].clrCap) begin
         loadEn[T_BAUX] = 1'b1;
      end
      if (wrap[T_BCORE] && ctrl[T_BCORE].relEn) begin
         loadEn[T_BCORE] = 1'b1;
         loadVal[T_BCORE] = capture_reload_reg;
      end
      for (int i = 0; i < NUM_TMR; i++) begin
         if (swLoad[i]) begin
            loadEn[i] = 1'b1;
            loadVal[i] = applyStrb(tVal[i], wData, wStrb);
         end
      end
   end

   // The five timers
   for (genvar g = 0; g < NUM_TMR; g++) begin : gTmr
      gpt_timer16 #(.TW(TMR_W)) uTmr (
         .clk_sys (clk_sys),
         .reset_n (reset_n),
         .ce      (ce),
         .cntEn   (cntEn[g]),
         .down    (dn[g]),
         .load    (loadEn[g]),
         .loadVal (loadVal[g]),
         .value   (tVal[g]),
         .wrap    (wrap[g])
      );
   end

   // Control registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_TMR; i++) begin
            ctrl[i] <= gpt_ctrl_t'(CTRL_RST[14:0]);
         end
      end else if (ce) begin
         for (int i = 0; i < NUM_TMR; i++) begin
            if (swCtrl[i]) begin
               ctrl[i] <= gpt_ctrl_t'(applyStrb({1'b0, ctrl[i]}, wData,
                                                wStrb) & 16'h7FFF);
            end
         end
      end
   end

   // Capture register; a capture beats a software write in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         capture_reload_reg <= VAL_RST;
      end else if (ce) begin
         if (capEv) begin
            capture_reload_reg <= tVal[T_BAUX];
         end else if (swCap) begin
            capture_reload_reg <= applyStrb(capture_reload_reg, wData, wStrb);
         end
      end
   end

   // Toggle latches and event outputs
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aLatch <= 1'b0;
         aToggleOut <= 1'b0;
         bToggleOut <= 1'b0;
         capcomTick <= 1'b0;
         irqBAux <= 1'b0;
         irqBCore <= 1'b0;
         irqCap <= 1'b0;
      end else if (ce) begin
         aLatch <= aLatch ^ wrap[T_ACORE];
         aToggleOut <= aLatch ^ wrap[T_ACORE];
         bToggleOut <= bToggleOut ^ wrap[T_BCORE];
         capcomTick <= wrap[T_BCORE];
         irqBAux <= wrap[T_BAUX];
         irqBCore <= wrap[T_BCORE];
         irqCap <= capEv;
      end
   end

   // Read decode
   always_comb begin
      rdData = '0;
      rdHit = 1'b0;
      for (int i = 0; i < NUM_TMR; i++) begin
         if ({s_axi_araddr[AW-1:2], 2'b00} == regAddr(OFF_CTRL0, i)) begin
            rdData = {17'h00000, ctrl[i]};
            rdHit = 1'b1;
         end
         if ({s_axi_araddr[AW-1:2], 2'b00} == regAddr(OFF_VAL0, i)) begin
            rdData = {16'h0000, tVal[i]};
            rdHit = 1'b1;
         end
      end
      if ({s_axi_araddr[AW-1:2], 2'b00} == OFF_CAPTURE_RELOAD_REG) begin
         rdData = {16'h0000, capture_reload_reg};
         rdHit = 1'b1;
      end
   end

   // AXI4-Lite channels; one write and one read outstanding
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awAddr <= {s_axi_awaddr[AW-1:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMap ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   AST_A_LATCH: assert property (ce && wrap[T_ACORE] |=>
      aToggleOut != $past(aToggleOut)) else $error("core A latch stuck");
   AST_B_LATCH: assert property (ce && wrap[T_BCORE] |=>
      bToggleOut != $past(bToggleOut)) else $error("core B latch stuck");
   AST_CAPCOM: assert property (ce && wrap[T_BCORE] |=>
      capcomTick) else $error("capcom tick missing");
   AST_RELOAD: assert property (ce && wrap[T_BCORE] &&
      ctrl[T_BCORE].relEn && !swLoad[T_BCORE] |=>
      tVal[T_BCORE] == $past(capture_reload_reg)) else $error("core B no reload");
   AST_CAPTURE: assert property (ce && capEv |=>
      capture_reload_reg == $past(tVal[T_BAUX])) else $error("capture lost");
   AST_CLEAR: assert property (ce && capEv && ctrl[T_BAUX].clrCap &&
      !swLoad[T_BAUX] |=> tVal[T_BAUX] == 16'h0000)
      else $error("aux B not cleared");
   AST_IRQ_CAP: assert property (ce && capEv |=> irqCap)
      else $error("capture request missing");
   AST_WRAP: assert property (ce && cntEn[T_BAUX] && !dn[T_BAUX] &&
      tVal[T_BAUX] == 16'hFFFF && !loadEn[T_BAUX] |=>
      tVal[T_BAUX] == 16'h0000) else $error("wrap not modulo");
   AST_PRESC_A: assert property (ctrl[T_ACORE].mode == MODE_TIMER &&
      ctrl[T_ACORE].inSel == 3'h0 && cntEn[T_ACORE] |->
      preCnt[2:0] == 3'h7) else $error("divide by 8 broken");
   AST_PRESC_B: assert property (ctrl[T_BCORE].mode == MODE_TIMER &&
      ctrl[T_BCORE].inSel == 3'h0 && cntEn[T_BCORE] |->
      preCnt[1:0] == 2'h3) else $error("divide by 4 broken");
   AST_GATE: assert property (ctrl[T_AHIGH].mode == MODE_GATEHI &&
      !inLvl[T_AHIGH] |-> !cntEn[T_AHIGH]) else $error("gate ignored");

   COV_CAPTURE: cover property (ce && capEv && ctrl[T_BAUX].clrCap);
   COV_RELOAD: cover property (ce && wrap[T_BCORE] && ctrl[T_BCORE].relEn);
   COV_QUAD: cover property (cntEn[T_ACORE] &&
      ctrl[T_ACORE].mode == MODE_INCR && dn[T_ACORE]);
   COV_CHAIN: cover property (cntEn[T_AHIGH] &&
      ctrl[T_AHIGH].mode == MODE_CHAIN);
endmodule // gpt_top

//--- sim/gpt_pin_model.sv
// Pin-side model: quadrature sensor plus bench-set pin levels
`timescale 1ns/10ps
module gpt_pin_model import gpt_pkg::*; (
   // Clock
   input  wire logic      clk_sys,
   // Bench requests
   input  wire logic      stepUp,
   input  wire logic      stepDn,
   input  wire gpt_pins_t lvl,
   // Pins toward the block
   output gpt_pins_t      pinIn
);
   logic [1:0] pos = 2'h0;

   // One phase edge per step, so x4 decode sees one count
   always @(posedge clk_sys) begin
      if (stepUp) begin
         pos <= pos + 2'h1;
      end else if (stepDn) begin
         pos <= pos - 2'h1;
      end
   end

   // Phase A on core input, phase B on core direction; A leads forward
   assign pinIn = lvl ^ {7'h00, pos[1], 2'h0, ^pos};
endmodule // gpt_pin_model

//--- sim/gpt_top_tb.sv
// Self-checking bench for the general purpose timer unit
`timescale 1ns/10ps
module gpt_top_tb import gpt_pkg::*;;
   // Control flags above the mode field
   localparam logic [9:0] RUN = 10'h001, DN = 10'h002, XD = 10'h004;
   localparam logic [9:0] ER = 10'h008, EB = 10'h018, REL = 10'h020;
   localparam logic [9:0] CLR = 10'h040;
   logic          clk_sys, reset_n, ce, stepUp, stepDn, b;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata, rv, v0;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp, rr;
   logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic          s_axi_rvalid, s_axi_rready, irqBAux, irqBCore, irqCap;
   logic          aToggleOut, bToggleOut, capcomTick;
   gpt_pins_t     pinIn, lvl;
   int            numErrors, checksDone, cyc, tAr;

   gpt_top uut (.clk_sys, .reset_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .aToggleOut,
      .bToggleOut, .capcomTick, .irqBAux, .irqBCore, .irqCap);
   gpt_pin_model pins (.clk_sys, .stepUp, .stepDn, .lvl, .pinIn);

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   function automatic logic [7:0] ra(input int i);
      return 8'(i) * REG_STRIDE;
   endfunction
   function automatic logic [15:0] cw(gpt_mode_t m, logic [2:0] s,
                                      logic [9:0] f);
      return {f, m, s};
   endfunction

   task automatic chk(input string n, input logic [31:0] e, s);
      checksDone++;
      if (s !== e) begin
         numErrors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Address and data channels are released independently
      fork
         begin
            do @(posedge clk_sys); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge clk_sys); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge clk_sys); while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      tAr = cyc;
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Ticks over a measured gap: floor or ceil, phase is unknown
   task automatic meas(input int i, input logic [15:0] c, input int sp,
                       input int dv, input bit dn);
      int g;
      logic [15:0] d, lo;
      wr(OFF_CTRL0 + ra(i), c);
      rd(OFF_VAL0 + ra(i));
      g = tAr;
      d = rv[15:0];
      repeat (sp) @(posedge clk_sys);
      rd(OFF_VAL0 + ra(i));
      g = tAr - g;
      d = dn ? d - rv[15:0] : rv[15:0] - d;
      lo = (dv == 0) ? 16'h0000 : 16'(g / dv);
      if (dv != 0 && g % dv != 0 && d == lo + 16'h0001) lo = d;
      chk("count delta", {16'h0000, lo}, {16'h0000, d});
   endtask

   task automatic waitFor(ref logic s, input logic v, input string n);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (s !== v && k < 300);
      chk(n, {31'h0, v}, {31'h0, s});
   endtask

   task automatic pulse(input int bt, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         lvl[bt] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         lvl[bt] <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask

   task automatic step(input bit up, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         stepUp <= up;
         stepDn <= !up;
         @(posedge clk_sys);
         stepUp <= 1'b0;
         stepDn <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask

   task automatic stopTest;
      $display("checks %0d mismatches %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Runaway guard, a few times the expected run
   initial begin
      repeat (30000) @(posedge clk_sys);
      numErrors++;
      stopTest;
   end

   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      {stepUp, stepDn, lvl, reset_n} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'h3;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd(OFF_CTRL0 + ra(i));
         chk("reset value", {16'h0000, CTRL_RST}, rv);
      end
      rd(8'h2C);
      chk("unmapped read", {RESP_SLVERR, 30'h0}, {rr, rv[29:0]});
      wr(8'h2C, 16'h5555);
      chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rr});
      wr(OFF_CTRL0 + ra(T_AHIGH), 16'hFFFF);
      rd(OFF_CTRL0 + ra(T_AHIGH));
      chk("control word", 32'h7FFF, rv);
      wr(OFF_CTRL0 + ra(T_AHIGH), 16'h0000);
      wr(OFF_VAL0 + ra(T_BAUX), 16'hA5C3);
      rd(OFF_VAL0 + ra(T_BAUX));
      chk("value word", 32'hA5C3, rv);
      $display("register test done");
      for (int s = 0; s < 8; s++) begin
         meas(T_ACORE, cw(MODE_TIMER, 3'(s), RUN), 16 << s, 8 << s, 0);
         meas(T_BCORE, cw(MODE_TIMER, 3'(s), RUN), 8 << s, 4 << s, 0);
      end
      meas(T_BAUX, cw(MODE_TIMER, 3'h0, RUN | DN), 64, 4, 1);
      lvl[8] <= 1'b1;
      meas(T_BAUX, cw(MODE_TIMER, 3'h0, RUN | XD), 64, 4, 1);
      lvl[8] <= 1'b0;
      meas(T_AHIGH, cw(MODE_GATEHI, 3'h0, RUN), 64, 0, 0);
      lvl[2] <= 1'b1;
      meas(T_AHIGH, cw(MODE_GATEHI, 3'h0, RUN), 64, 8, 0);
      meas(T_AHIGH, cw(MODE_GATELO, 3'h0, RUN), 64, 0, 0);
      lvl[2] <= 1'b0;
      $display("prescaler and direction test done");
      wr(OFF_CTRL0 + ra(T_ALOW), cw(MODE_COUNT, 3'h0, RUN | ER));
      rd(OFF_VAL0 + ra(T_ALOW));
      v0 = rv;
      pulse(1, 5);
      rd(OFF_VAL0 + ra(T_ALOW));
      chk("event count", v0 + 32'h5, rv);
      wr(OFF_CTRL0 + ra(T_ACORE), cw(MODE_INCR, 3'h0, RUN));
      rd(OFF_VAL0 + ra(T_ACORE));
      v0 = rv;
      step(1, 8);
      rd(OFF_VAL0 + ra(T_ACORE));
      chk("sensor forward", {16'h0000, v0[15:0] + 16'h0008}, rv);
      step(0, 3);
      rd(OFF_VAL0 + ra(T_ACORE));
      chk("sensor back", {16'h0000, v0[15:0] + 16'h0005}, rv);
      $display("counter and sensor test done");
      wr(OFF_VAL0 + ra(T_ALOW), 16'h0100);
      wr(OFF_CTRL0 + ra(T_ALOW), cw(MODE_RELOAD, 3'h0, RUN));
      wr(OFF_CTRL0 + ra(T_AHIGH), cw(MODE_CHAIN, 3'h0, RUN | EB));
      rd(OFF_VAL0 + ra(T_AHIGH));
      v0 = rv;
      b = aToggleOut;
      wr(OFF_VAL0 + ra(T_ACORE), 16'hFFFE);
      wr(OFF_CTRL0 + ra(T_ACORE), cw(MODE_TIMER, 3'h0, RUN));
      waitFor(aToggleOut, !b, "a toggle up");
      rd(OFF_VAL0 + ra(T_ACORE));
      chk("a reload", 32'h1, 32'(rv >= 32'h0100 && rv < 32'h0104));
      rd(OFF_VAL0 + ra(T_AHIGH));
      chk("chained count", v0 + 32'h1, rv);
      wr(OFF_CTRL0 + ra(T_ALOW), cw(MODE_CAPTURE, 3'h0, RUN | ER));
      pulse(1, 1);
      rd(OFF_VAL0 + ra(T_ALOW));
      chk("a capture", 32'h1, 32'(rv - 32'h0101 < 32'hF));
      wr(OFF_VAL0 + ra(T_ACORE), 16'h0001);
      wr(OFF_CTRL0 + ra(T_ACORE), cw(MODE_TIMER, 3'h0, RUN | DN));
      waitFor(aToggleOut, b, "a toggle down");
      wr(OFF_CAPTURE_RELOAD_REG, 16'h1234);
      wr(OFF_VAL0 + ra(T_BCORE), 16'hFFF0);
      b = bToggleOut;
      wr(OFF_CTRL0 + ra(T_BCORE), cw(MODE_TIMER, 3'h0, RUN | REL));
      waitFor(irqBCore, 1'b1, "b core request");
      chk("capcom tick", 32'h1, {31'h0, capcomTick});
      chk("b toggle", {31'h0, !b}, {31'h0, bToggleOut});
      rd(OFF_VAL0 + ra(T_BCORE));
      chk("b reload", 32'h1, 32'(rv >= 32'h1234 && rv < 32'h1238));
      wr(OFF_VAL0 + ra(T_BAUX), 16'hFFF8);
      wr(OFF_CTRL0 + ra(T_BAUX), cw(MODE_TIMER, 3'h0, RUN));
      waitFor(irqBAux, 1'b1, "b aux request");
      $display("wrap test done");
      wr(OFF_CTRL0 + ra(T_BAUX), cw(MODE_TIMER, 3'h0, RUN | REL | CLR | ER));
      repeat (100) @(posedge clk_sys);
      lvl[10] <= 1'b1;
      waitFor(irqCap, 1'b1, "capture request");
      rd(OFF_CAPTURE_RELOAD_REG);
      v0 = rv;
      rd(OFF_VAL0 + ra(T_BAUX));
      chk("capture clear", 32'h1, 32'(v0 > 32'h8 && rv < 32'h8));
      for (int k = 1; k < 3; k++) begin
         wr(OFF_CTRL0 + ra(T_BAUX), cw(MODE_TIMER, 3'h0,
            RUN | REL | 10'(k << 7)));
         lvl[3 * k - 3] <= ~lvl[3 * k - 3];
         waitFor(irqCap, 1'b1, "core pin capture");
      end
      $display("capture test done");
      stopTest;
   end
endmodule // gpt_top_tb
